// ===== src/ppf_cfg.svh
`ifndef PPF_CFG_SVH
`define PPF_CFG_SVH

// Register offsets in the control block's space
`define PPF_OFF_PA_CTRL  8'h02
`define PPF_OFF_PB_CTRL  8'h03
`define PPF_OFF_PA_DIR   8'h06
`define PPF_OFF_PB_DIR   8'h07
`define PPF_OFF_PA_DRV   8'h08
`define PPF_OFF_PB_DRV   8'h09
`define PPF_OFF_PA_OE    8'h0c
`define PPF_OFF_PB_OE    8'h0d

`define PPF_RST_BYTE     8'h00
`define PPF_ZERO_BYTE    8'h00
`define PPF_ALL_ONES     8'hff

// Drive-select field layout: upper nibble open drain, lower nibble fast slew
`define PPF_OD_MASK      8'hf0
`define PPF_SLEW_MASK    8'h0f

`endif

// ===== src/ppf_drv_if.sv
`timescale 1ns/1ps
interface ppf_drv_if;
  import ppf_pkg::*;

  ppf_byte_t sel_out;
  ppf_byte_t sel_oe;
  ppf_byte_t od_en;
  ppf_byte_t fast_en;
  ppf_byte_t pin_out;
  ppf_byte_t pin_oe;
  ppf_byte_t pin_od;
  ppf_byte_t pin_fast;

  modport ctl (output sel_out, output sel_oe, output od_en, output fast_en,
               input  pin_out, input  pin_oe, input  pin_od, input  pin_fast);
  modport drv (input  sel_out, input  sel_oe, input  od_en, input  fast_en,
               output pin_out, output pin_oe, output pin_od, output pin_fast);
endinterface

// ===== src/ppf_pin_drv.sv
`timescale 1ns/1ps
`include "ppf_cfg.svh"
module ppf_pin_drv (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  ppf_drv_if.drv    port
);
  import ppf_pkg::*;

  ppf_byte_t od_eff;

  // Open drain only sinks: a 1 releases the pin
  assign od_eff = port.od_en & `PPF_OD_MASK;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      port.pin_out  <= `PPF_RST_BYTE;
      port.pin_oe   <= `PPF_RST_BYTE;
      port.pin_od   <= `PPF_RST_BYTE;
      port.pin_fast <= `PPF_RST_BYTE;
    end else begin
      port.pin_out  <= port.sel_out;
      port.pin_oe   <= port.sel_oe & ~(od_eff & port.sel_out);
      port.pin_od   <= od_eff;
      port.pin_fast <= port.fast_en & `PPF_SLEW_MASK;
    end
  end
endmodule

// ===== src/ppf_pkg.sv
package ppf_pkg;

  typedef logic [7:0] ppf_byte_t;

  typedef enum logic [3:0] {
    PPF_SEL_NONE    = 4'b0000,
    PPF_SEL_PA_CTRL = 4'b0001,
    PPF_SEL_PB_CTRL = 4'b0010,
    PPF_SEL_PA_DIR  = 4'b0011,
    PPF_SEL_PB_DIR  = 4'b0100,
    PPF_SEL_PA_DRV  = 4'b0101,
    PPF_SEL_PB_DRV  = 4'b0110,
    PPF_SEL_PA_OE   = 4'b0111,
    PPF_SEL_PB_OE   = 4'b1000
  } ppf_reg_sel_t;

endpackage

// ===== src/ppf_sync.sv
`timescale 1ns/1ps
module ppf_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  initial begin
    if (WIDTH < 1) $error("ppf_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Bits only move once the last two stages agree, filtering single glitches
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sync <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_sync[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ===== src/ppf_top.sv
// Operation
// - Control bit set drives latched address
// - Low byte on A,B; high byte B only
// - Address taken from multiplexed bus
// - Address control registers reset to zero
// - Port A repeats data, direction from strobes
// - Repeater window is OR of selects
// - Repeat whenever address hits select range
// - Peripheral mode takes all eight pins
// - Peripheral mode excludes other pin functions
// - Drive bit one selects open drain
// - Drive bit one selects fast slew
// - Pins default push-pull, normal slew
// - Drive select writable at any time
// - Port A drive bits: 7-4 drain, 3-0 slew
// - Enable-out read shows combined enable, before open-drain release
// - OE from logic term, direction, address control bit, repeater
// - Enable-out reflects final combined enable; the read here gives the enable before open-drain release
// - Output enable ORs logic term, direction and address control bit
// - Direction one is output, resets zero
`timescale 1ns/1ps
`include "ppf_cfg.svh"
module ppf_top (
  input  wire logic           i_mclk,
  input  wire logic           i_rst,
  // Register port
  input  wire logic [7:0]     i_reg_addr,
  input  wire logic           i_reg_wr,
  input  wire logic           i_reg_rd,
  input  wire ppf_pkg::ppf_byte_t i_reg_wdata,
  output ppf_pkg::ppf_byte_t  o_reg_rdata,
  output logic                o_reg_rvalid,
  // Multiplexed CPU bus
  input  wire ppf_pkg::ppf_byte_t i_ad,
  input  wire ppf_pkg::ppf_byte_t i_addr_hi,
  input  wire logic           i_ale,
  input  wire logic           i_rd_n,
  input  wire logic           i_wr_n,
  output ppf_pkg::ppf_byte_t  o_periph_rdata,
  output logic                o_periph_rd_active,
  // Decode and configuration
  input  wire logic           i_periph_select_zero,
  input  wire logic           i_periph_select_one,
  input  wire logic           i_periph_repeater_enable,
  input  wire logic           i_cfg_pa_periph_mode,
  input  wire ppf_pkg::ppf_byte_t i_cfg_pb_high_byte,
  // Logic array and MCU data-out sources
  input  wire ppf_pkg::ppf_byte_t i_pa_pld_sel,
  input  wire ppf_pkg::ppf_byte_t i_pa_pld_out,
  input  wire ppf_pkg::ppf_byte_t i_pa_pld_oe,
  input  wire ppf_pkg::ppf_byte_t i_pa_mcu_dout,
  input  wire ppf_pkg::ppf_byte_t i_pb_pld_sel,
  input  wire ppf_pkg::ppf_byte_t i_pb_pld_out,
  input  wire ppf_pkg::ppf_byte_t i_pb_pld_oe,
  input  wire ppf_pkg::ppf_byte_t i_pb_mcu_dout,
  // Pins
  input  wire ppf_pkg::ppf_byte_t i_pa_pin,
  output ppf_pkg::ppf_byte_t  o_pa_in,
  output ppf_pkg::ppf_byte_t  o_pa_out,
  output ppf_pkg::ppf_byte_t  o_pa_oe,
  output ppf_pkg::ppf_byte_t  o_pa_open_drain,
  output ppf_pkg::ppf_byte_t  o_pa_fast_slew,
  input  wire ppf_pkg::ppf_byte_t i_pb_pin,
  output ppf_pkg::ppf_byte_t  o_pb_in,
  output ppf_pkg::ppf_byte_t  o_pb_out,
  output ppf_pkg::ppf_byte_t  o_pb_oe,
  output ppf_pkg::ppf_byte_t  o_pb_open_drain,
  output ppf_pkg::ppf_byte_t  o_pb_fast_slew
);
  import ppf_pkg::*;

  function automatic ppf_reg_sel_t decode(input logic [7:0] addr);
    ppf_reg_sel_t sel;
    sel = PPF_SEL_NONE;
    unique case (addr)
      `PPF_OFF_PA_CTRL: sel = PPF_SEL_PA_CTRL;
      `PPF_OFF_PB_CTRL: sel = PPF_SEL_PB_CTRL;
      `PPF_OFF_PA_DIR:  sel = PPF_SEL_PA_DIR;
      `PPF_OFF_PB_DIR:  sel = PPF_SEL_PB_DIR;
      `PPF_OFF_PA_DRV:  sel = PPF_SEL_PA_DRV;
      `PPF_OFF_PB_DRV:  sel = PPF_SEL_PB_DRV;
      `PPF_OFF_PA_OE:   sel = PPF_SEL_PA_OE;
      `PPF_OFF_PB_OE:   sel = PPF_SEL_PB_OE;
      default:          sel = PPF_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Per-bit pick of a priority source over a fallback
  function automatic ppf_byte_t pick(input ppf_byte_t mask, input ppf_byte_t hi,
                                     input ppf_byte_t lo);
    return (mask & hi) | (~mask & lo);
  endfunction

  ppf_reg_sel_t sel;
  ppf_byte_t    pa_ctrl_r;
  ppf_byte_t    pb_ctrl_r;
  ppf_byte_t    pa_dir_r;
  ppf_byte_t    pb_dir_r;
  ppf_byte_t    pa_drv_r;
  ppf_byte_t    pb_drv_r;
  ppf_byte_t    addr_lo_r;
  ppf_byte_t    addr_hi_r;
  logic         ale_r;
  logic         rep_win;
  logic         rep_active;
  logic         rep_write;
  logic         rep_read;
  ppf_byte_t    rep_data_r;
  ppf_byte_t    pa_addr_out;
  ppf_byte_t    pb_addr_out;
  ppf_byte_t    pa_addr_en;
  ppf_byte_t    pb_addr_en;
  ppf_byte_t    pa_oe_fin;
  ppf_byte_t    pb_oe_fin;
  ppf_byte_t    pa_out_fin;
  ppf_byte_t    pb_out_fin;
  ppf_byte_t    pa_sync;
  ppf_byte_t    pb_sync;
  ppf_byte_t    reg_rdata_nxt;

  ppf_drv_if pa_if ();
  ppf_drv_if pb_if ();

  assign sel = decode(i_reg_addr);

  // Register writes; drive select may change at any time
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pa_ctrl_r <= `PPF_RST_BYTE;
      pb_ctrl_r <= `PPF_RST_BYTE;
      pa_dir_r  <= `PPF_RST_BYTE;
      pb_dir_r  <= `PPF_RST_BYTE;
      pa_drv_r  <= `PPF_RST_BYTE;
      pb_drv_r  <= `PPF_RST_BYTE;
    end else if (i_reg_wr) begin
      unique case (sel)
        PPF_SEL_PA_CTRL: pa_ctrl_r <= i_reg_wdata;
        PPF_SEL_PB_CTRL: pb_ctrl_r <= i_reg_wdata;
        PPF_SEL_PA_DIR:  pa_dir_r  <= i_reg_wdata;
        PPF_SEL_PB_DIR:  pb_dir_r  <= i_reg_wdata;
        PPF_SEL_PA_DRV:  pa_drv_r  <= i_reg_wdata;
        PPF_SEL_PB_DRV:  pb_drv_r  <= i_reg_wdata;
        PPF_SEL_PA_OE, PPF_SEL_PB_OE, PPF_SEL_NONE: begin
        end
      endcase
    end
  end

  // Address latch: data shares the low lines, so only the strobe fall is trusted
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ale_r     <= 1'b0;
      addr_lo_r <= `PPF_RST_BYTE;
      addr_hi_r <= `PPF_RST_BYTE;
    end else begin
      // Limitation: a strobe high for less than one clock is missed unless it spans a rising edge of i_mclk
      ale_r <= i_ale;
      if (ale_r && !i_ale) begin
        addr_lo_r <= i_ad;
        addr_hi_r <= i_addr_hi;
      end
    end
  end

  // Port B bit n carries address bit n or n+8 per configured byte
  assign pa_addr_out = addr_lo_r;
  assign pb_addr_out = pick(i_cfg_pb_high_byte, addr_hi_r, addr_lo_r);

  // Repeater window; the select decode is expected to exclude code fetches
  assign rep_win    = i_periph_select_zero | i_periph_select_one;
  assign rep_active = i_cfg_pa_periph_mode & i_periph_repeater_enable & rep_win;
  assign rep_write  = rep_active & ~i_wr_n;
  assign rep_read   = rep_active & ~i_rd_n;

  // Write data is held so the pin keeps it after the strobe edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rep_data_r <= `PPF_RST_BYTE;
    end else if (rep_write) begin
      rep_data_r <= i_ad;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_periph_rdata     <= `PPF_RST_BYTE;
      o_periph_rd_active <= 1'b0;
    end else begin
      o_periph_rd_active <= rep_read;
      if (rep_read) begin
        o_periph_rdata <= pa_sync;
      end
    end
  end

  // Logic array outputs own their pins; address mode beats plain MCU I/O
  assign pa_addr_en = pa_ctrl_r & ~i_pa_pld_sel;
  assign pb_addr_en = pb_ctrl_r & ~i_pb_pld_sel;

  always_comb begin
    if (i_cfg_pa_periph_mode) begin
      // All eight pins follow the repeater alone
      // Live bus byte during a write, else a stale byte would drive for a cycle
      if (rep_write) begin
        pa_out_fin = i_ad;
      end else begin
        pa_out_fin = rep_data_r;
      end
      pa_oe_fin  = rep_write ? `PPF_ALL_ONES : `PPF_ZERO_BYTE;
    end else begin
      pa_out_fin = pick(i_pa_pld_sel, i_pa_pld_out,
                        pick(pa_addr_en, pa_addr_out, i_pa_mcu_dout));
      pa_oe_fin  = i_pa_pld_oe | pa_dir_r | pa_addr_en;
    end
  end

  assign pb_out_fin = pick(i_pb_pld_sel, i_pb_pld_out,
                           pick(pb_addr_en, pb_addr_out, i_pb_mcu_dout));
  assign pb_oe_fin  = i_pb_pld_oe | pb_dir_r | pb_addr_en;

  assign pa_if.sel_out = pa_out_fin;
  assign pa_if.sel_oe  = pa_oe_fin;
  assign pa_if.od_en   = pa_drv_r;
  assign pa_if.fast_en = pa_drv_r;
  assign pb_if.sel_out = pb_out_fin;
  assign pb_if.sel_oe  = pb_oe_fin;
  assign pb_if.od_en   = pb_drv_r;
  assign pb_if.fast_en = pb_drv_r;

  ppf_pin_drv u_pa_drv (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .port   (pa_if.drv)
  );

  ppf_pin_drv u_pb_drv (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .port   (pb_if.drv)
  );

  assign o_pa_out        = pa_if.pin_out;
  assign o_pa_oe         = pa_if.pin_oe;
  assign o_pa_open_drain = pa_if.pin_od;
  assign o_pa_fast_slew  = pa_if.pin_fast;
  assign o_pb_out        = pb_if.pin_out;
  assign o_pb_oe         = pb_if.pin_oe;
  assign o_pb_open_drain = pb_if.pin_od;
  assign o_pb_fast_slew  = pb_if.pin_fast;

  // Pin levels are asynchronous: three stages, a change taken once two agree
  ppf_sync #(.WIDTH(8)) u_pa_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async (i_pa_pin),
    .o_sync  (pa_sync)
  );

  ppf_sync #(.WIDTH(8)) u_pb_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async (i_pb_pin),
    .o_sync  (pb_sync)
  );

  assign o_pa_in = pa_sync;
  assign o_pb_in = pb_sync;

  // Read-back; enable-out shows the combined enable before open-drain release
  always_comb begin
    reg_rdata_nxt = `PPF_ZERO_BYTE;
    unique case (sel)
      PPF_SEL_PA_CTRL: reg_rdata_nxt = pa_ctrl_r;
      PPF_SEL_PB_CTRL: reg_rdata_nxt = pb_ctrl_r;
      PPF_SEL_PA_DIR:  reg_rdata_nxt = pa_dir_r;
      PPF_SEL_PB_DIR:  reg_rdata_nxt = pb_dir_r;
      PPF_SEL_PA_DRV:  reg_rdata_nxt = pa_drv_r;
      PPF_SEL_PB_DRV:  reg_rdata_nxt = pb_drv_r;
      PPF_SEL_PA_OE:   reg_rdata_nxt = pa_oe_fin;
      PPF_SEL_PB_OE:   reg_rdata_nxt = pb_oe_fin;
      PPF_SEL_NONE:    reg_rdata_nxt = `PPF_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_reg_rdata  <= `PPF_RST_BYTE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      // Read data only moves on a read, so it stands until the next one
      if (i_reg_rd) begin
        o_reg_rdata <= reg_rdata_nxt;
      end
    end
  end
endmodule

// ===== test/ppf_periph_model.sv
`timescale 1ns/1ps
module ppf_periph_model (
  input  wire logic               i_mclk,
  input  wire logic               i_sel,
  input  wire logic               i_rd_n,
  input  wire logic               i_wr_n,
  input  wire ppf_pkg::ppf_byte_t i_pa_out,
  input  wire ppf_pkg::ppf_byte_t i_pa_oe,
  output ppf_pkg::ppf_byte_t      o_pin
);
  import ppf_pkg::*;
  ppf_byte_t mem_r = 8'h00;
  logic      drive;
  // Undriven bits float to the pull-up level
  assign drive = i_sel && !i_rd_n;
  assign o_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & (drive ? mem_r : 8'hff));
  always @(posedge i_mclk) begin
    if (i_sel && !i_wr_n && i_pa_oe == 8'hff) begin
      mem_r <= o_pin;
    end
  end
endmodule

// ===== test/ppf_properties.sv
`timescale 1ns/1ps
module ppf_properties (
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire logic [7:0]         i_reg_addr,
  input wire logic               i_reg_wr,
  input wire logic               i_reg_rd,
  input wire ppf_pkg::ppf_byte_t i_reg_wdata,
  input wire logic               o_reg_rvalid,
  input wire ppf_pkg::ppf_byte_t i_ad,
  input wire logic               i_rd_n,
  input wire logic               i_wr_n,
  input wire logic               i_periph_select_zero,
  input wire logic               i_periph_select_one,
  input wire logic               i_periph_repeater_enable,
  input wire logic               i_cfg_pa_periph_mode,
  input wire logic               o_periph_rd_active,
  input wire ppf_pkg::ppf_byte_t o_pa_out,
  input wire ppf_pkg::ppf_byte_t o_pa_oe,
  input wire ppf_pkg::ppf_byte_t o_pa_open_drain,
  input wire ppf_pkg::ppf_byte_t o_pa_fast_slew,
  input wire ppf_pkg::ppf_byte_t o_pb_out
);
  import ppf_pkg::*;
  logic rep_on;
  assign rep_on = i_cfg_pa_periph_mode && i_periph_repeater_enable
                  && (i_periph_select_zero || i_periph_select_one);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=>
    (o_pa_oe == 8'h00 && o_pb_out == 8'h00 && o_pa_open_drain == 8'h00))
    else $error("outputs not cleared by reset");
  a_drive_write: assert property (i_reg_wr && i_reg_addr == 8'h08 |=> ##1
    (o_pa_open_drain == ($past(i_reg_wdata, 2) & 8'hf0)
     && o_pa_fast_slew == ($past(i_reg_wdata, 2) & 8'h0f)))
    else $error("drive select write not applied");
  a_drive_split: assert property ((o_pa_open_drain & 8'h0f) == 8'h00
    && (o_pa_fast_slew & 8'hf0) == 8'h00) else $error("drive type on wrong pin");
  a_repeat_write: assert property (rep_on && !i_wr_n |=>
    ((o_pa_oe | o_pa_open_drain) == 8'hff && o_pa_out == $past(i_ad)))
    else $error("repeater write not driven");
  a_repeat_read: assert property (rep_on && !i_rd_n |=> o_periph_rd_active)
    else $error("repeater read not active");
  a_read_idle: assert property (!(rep_on && !i_rd_n) |=> !o_periph_rd_active)
    else $error("repeater read without select");
  a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without read");
  c_rep_write: cover property (rep_on && !i_wr_n);
  c_rep_read: cover property (rep_on && !i_rd_n);
  c_drive_write: cover property (i_reg_wr && i_reg_addr == 8'h08);
endmodule

// ===== test/test_port_pin_function_control.sv
`timescale 1ns/1ps
module test_port_pin_function_control;
  import ppf_pkg::*;
  logic i_mclk, i_rst, i_reg_wr, i_reg_rd, i_ale, i_rd_n, i_wr_n, o_reg_rvalid;
  logic i_periph_select_zero, i_periph_select_one, i_periph_repeater_enable;
  logic i_cfg_pa_periph_mode, o_periph_rd_active;
  logic [7:0] i_reg_addr;
  ppf_byte_t i_reg_wdata, i_ad, i_addr_hi, i_cfg_pb_high_byte, i_pa_pld_sel, i_pa_pld_out;
  ppf_byte_t i_pa_pld_oe, i_pa_mcu_dout, i_pb_pld_sel, i_pb_pld_out, i_pb_pld_oe;
  ppf_byte_t i_pb_mcu_dout, i_pa_pin, i_pb_pin, o_reg_rdata, o_periph_rdata, o_pa_in;
  ppf_byte_t o_pa_out, o_pa_oe, o_pa_open_drain, o_pa_fast_slew, o_pb_in, o_pb_out;
  ppf_byte_t o_pb_oe, o_pb_open_drain, o_pb_fast_slew;
  int fails, checked;
  ppf_byte_t addrs[9] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h20};

  ppf_top i_ppf_top (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_ad, .i_addr_hi, .i_ale, .i_rd_n, .i_wr_n,
    .o_periph_rdata, .o_periph_rd_active, .i_periph_select_zero, .i_periph_select_one,
    .i_periph_repeater_enable, .i_cfg_pa_periph_mode, .i_cfg_pb_high_byte, .i_pa_pld_sel,
    .i_pa_pld_out, .i_pa_pld_oe, .i_pa_mcu_dout, .i_pb_pld_sel, .i_pb_pld_out,
    .i_pb_pld_oe, .i_pb_mcu_dout, .i_pa_pin, .o_pa_in, .o_pa_out, .o_pa_oe,
    .o_pa_open_drain, .o_pa_fast_slew, .i_pb_pin, .o_pb_in, .o_pb_out, .o_pb_oe,
    .o_pb_open_drain, .o_pb_fast_slew);
  ppf_periph_model i_ppf_periph_model (.i_mclk, .i_rd_n, .i_wr_n, .i_pa_out(o_pa_out),
    .i_sel(i_periph_select_zero | i_periph_select_one), .i_pa_oe(o_pa_oe), .o_pin(i_pa_pin));
  // Port B pins pulled up where not driven
  assign i_pb_pin = (o_pb_oe & o_pb_out) | ~o_pb_oe;

  task chk(input ppf_byte_t got, input ppf_byte_t exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input ppf_byte_t a, input ppf_byte_t d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask
  task rd(input ppf_byte_t a, input ppf_byte_t exp);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1;
    chk({7'h00, o_reg_rvalid}, 8'h01);
    chk(o_reg_rdata, exp);
  endtask
  task settle;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
  initial begin
    {i_reg_wr, i_reg_rd, i_ale, i_periph_select_zero, i_periph_select_one} = '0;
    {i_periph_repeater_enable, i_cfg_pa_periph_mode} = '0;
    {i_reg_addr, i_reg_wdata, i_ad, i_addr_hi, i_cfg_pb_high_byte, i_pa_pld_sel} = '0;
    {i_pa_pld_out, i_pa_pld_oe, i_pa_mcu_dout, i_pb_pld_sel, i_pb_pld_out} = '0;
    {i_pb_pld_oe, i_pb_mcu_dout} = '0;
    {i_rd_n, i_wr_n, i_rst} = 3'b111;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    // Reset values, unmapped place reads zero
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    chk(o_pa_open_drain | o_pa_fast_slew | o_pb_open_drain | o_pb_fast_slew, 8'h00);
    wr(8'h08, 8'ha5);
    rd(8'h08, 8'ha5);
    chk(o_pa_open_drain, 8'ha0);
    chk(o_pa_fast_slew, 8'h05);
    wr(8'h09, 8'h3c);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'hff);
    settle();
    chk(o_pb_open_drain, 8'h30);
    chk(o_pb_fast_slew, 8'h0c);
    chk(o_pa_open_drain, 8'h00);
    rd(8'h0c, 8'h00);
    wr(8'h09, 8'h00);
    i_pb_pld_oe <= 8'h30;
    wr(8'h07, 8'h0f);
    settle();
    chk(o_pb_oe, 8'h3f);
    rd(8'h0d, 8'h3f);
    rd(8'h07, 8'h0f);
    @(posedge i_mclk);
    // Mixed byte lanes on Port B, low nibble stays MCU I/O
    i_pb_mcu_dout <= 8'h09;
    i_cfg_pb_high_byte <= 8'hc0;
    wr(8'h03, 8'hf0);
    wr(8'h02, 8'h0f);
    @(posedge i_mclk);
    i_ale <= 1'b1;
    i_ad <= 8'ha5;
    i_addr_hi <= 8'h6c;
    @(posedge i_mclk);
    i_ale <= 1'b0;
    @(posedge i_mclk);
    i_ad <= 8'h00;
    settle();
    chk(o_pb_out, 8'h69);
    chk(o_pa_out, 8'h05);
    chk(o_pb_oe, 8'hff);
    rd(8'h0d, 8'hff);
    // Open drain releases pins driving a one; enable-out still reads combined
    wr(8'h09, 8'hf0);
    settle();
    chk(o_pb_oe, 8'h9f);
    rd(8'h0d, 8'hff);
    chk(o_pb_in, 8'h69);
    // Logic array outputs own their pins over address and MCU I/O
    @(posedge i_mclk);
    i_pb_pld_sel <= 8'h81;
    i_pb_pld_out <= 8'h80;
    settle();
    chk(o_pb_out, 8'he8);
    @(posedge i_mclk);
    i_cfg_pa_periph_mode <= 1'b1;
    i_periph_repeater_enable <= 1'b1;
    i_pa_pld_oe <= 8'hff;
    i_wr_n <= 1'b0;
    settle();
    chk(o_pa_oe, 8'h00);
    for (int s = 1; s < 3; s++) begin
      @(posedge i_mclk);
      i_periph_select_zero <= s[0];
      i_periph_select_one <= s[1];
      i_ad <= 8'h30 + 8'(s);
      i_wr_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
      chk(o_pa_oe, 8'hff);
      chk(o_pa_out, 8'h30 + 8'(s));
      @(posedge i_mclk);
      i_wr_n <= 1'b1;
      @(posedge i_mclk);
      i_rd_n <= 1'b0;
      repeat (6) @(posedge i_mclk);
      #1;
      chk({7'h00, o_periph_rd_active}, 8'h01);
      chk(o_periph_rdata, 8'h30 + 8'(s));
      chk(o_pa_in, 8'h30 + 8'(s));
      @(posedge i_mclk);
      i_rd_n <= 1'b1;
      {i_periph_select_zero, i_periph_select_one} <= 2'b00;
    end
    settle();
    print_verdict();
  end
endmodule

bind ppf_top ppf_properties i_ppf_properties (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wr,
  .i_reg_rd, .i_reg_wdata, .o_reg_rvalid, .i_ad, .i_rd_n, .i_wr_n, .i_periph_select_zero,
  .i_periph_select_one, .i_periph_repeater_enable, .i_cfg_pa_periph_mode,
  .o_periph_rd_active, .o_pa_out, .o_pa_oe, .o_pa_open_drain, .o_pa_fast_slew, .o_pb_out);
